/* File: gdf_pkg.sv */
`default_nettype none
package gdf_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] GDF_OFS = 8'hE0;
    localparam logic [7:0] CFS_OFS = 8'hE2;
    localparam logic [31:0] GDF_RESET = 32'h00000000;
    localparam logic [31:0] RD_IDLE = 32'h00000000;
    // Bit positions inside the gate driver fault register.
    localparam int BIT_SUMMARY = 31;
    localparam int BIT_BUCK_ANY = 30;
    localparam int BIT_OVERCUR_ANY = 28;
    localparam int BIT_SUPPLY_HIGH = 26;
    localparam int BIT_THERM_ANY = 25;
    localparam int BIT_THERM_WARN = 23;
    localparam int BIT_THERM_SHUT = 22;
    localparam int BIT_PHC_HIGH = 21;
    localparam int BIT_PHC_LOW = 20;
    localparam int BIT_PHB_HIGH = 19;
    localparam int BIT_PHB_LOW = 18;
    localparam int BIT_PHA_HIGH = 17;
    localparam int BIT_PHA_LOW = 16;
    localparam int BIT_OTP_ERR = 14;
    localparam int BIT_BUCK_OVERCUR = 13;
    localparam int BIT_BUCK_UNDERV = 12;
    localparam int BIT_PUMP_UNDERV = 11;
    // Bits that may ever read as one; all others are reserved.
    localparam logic [31:0] GDF_USED_MASK = 32'hD6FF7800;
    // Index of each latched detector inside the flag vector.
    localparam int NUM_DET = 13;
    localparam int DET_SUPPLY_HIGH = 0;
    localparam int DET_THERM_WARN = 1;
    localparam int DET_THERM_SHUT = 2;
    localparam int DET_PHA_LOW = 3;
    localparam int DET_PHA_HIGH = 4;
    localparam int DET_PHB_LOW = 5;
    localparam int DET_PHB_HIGH = 6;
    localparam int DET_PHC_LOW = 7;
    localparam int DET_PHC_HIGH = 8;
    localparam int DET_OTP_ERR = 9;
    localparam int DET_BUCK_OVERCUR = 10;
    localparam int DET_BUCK_UNDERV = 11;
    localparam int DET_PUMP_UNDERV = 12;
    localparam logic [NUM_DET-1:0] FLAGS_RESET = 13'h0000;
endpackage : gdf_pkg
`default_nettype wire

/* File: gdf_fault_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module gdf_fault_bank
    import gdf_pkg::*;
(
    input wire logic ref_clk, // 25 MHz clock.
    input wire logic reset, // Asynchronous, active high.
    input wire logic supply_overvoltage_det, // Motor supply overvoltage seen.
    input wire logic thermal_warning_det, // Overtemperature warning seen.
    input wire logic thermal_shutdown_det, // Overtemperature shutdown seen.
    input wire logic phase_a_low_side_oc_det, // Phase A low-side overcurrent.
    input wire logic phase_a_high_side_oc_det, // Phase A high-side overcurrent.
    input wire logic phase_b_low_side_oc_det, // Phase B low-side overcurrent.
    input wire logic phase_b_high_side_oc_det, // Phase B high-side overcurrent.
    input wire logic phase_c_low_side_oc_det, // Phase C low-side overcurrent.
    input wire logic phase_c_high_side_oc_det, // Phase C high-side overcurrent.
    input wire logic otp_error_det, // Programmable storage error seen.
    input wire logic buck_overcurrent_det, // Buck regulator overcurrent.
    input wire logic buck_undervoltage_det, // Buck regulator undervoltage.
    input wire logic charge_pump_undervoltage_det, // Charge pump undervoltage.
    input wire logic fault_clear, // One-cycle pulse clearing all flags except those detected in the same cycle.
    input wire logic [31:0] controller_fault_flags, // Controller status, read at E2h.
    input wire logic rd_en, // Read request for one cycle.
    input wire logic [ADDR_W-1:0] rd_addr, // Register offset of the read.
    output logic [DATA_W-1:0] rd_data, // Read data, valid with rd_valid.
    output logic rd_valid, // One-cycle pulse with read data.
    output logic rd_error, // Read hit a reserved offset.
    output logic driver_fault // Registered summary bit.
);

    logic [NUM_DET-1:0] det;
    logic [NUM_DET-1:0] flag_r;
    logic [NUM_DET-1:0] flag_nxt;
    logic [31:0] gdf_image;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic rd_valid_r;
    logic rd_error_r;
    logic rd_error_nxt;
    logic driver_fault_r;
    wire hit_gdf;
    wire hit_cfs;
    wire any_flag;
    wire overcur_any;
    wire buck_any;
    wire therm_any;

    assign det[DET_SUPPLY_HIGH] = supply_overvoltage_det;
    assign det[DET_THERM_WARN] = thermal_warning_det;
    assign det[DET_THERM_SHUT] = thermal_shutdown_det;
    assign det[DET_PHA_LOW] = phase_a_low_side_oc_det;
    assign det[DET_PHA_HIGH] = phase_a_high_side_oc_det;
    assign det[DET_PHB_LOW] = phase_b_low_side_oc_det;
    assign det[DET_PHB_HIGH] = phase_b_high_side_oc_det;
    assign det[DET_PHC_LOW] = phase_c_low_side_oc_det;
    assign det[DET_PHC_HIGH] = phase_c_high_side_oc_det;
    assign det[DET_OTP_ERR] = otp_error_det;
    assign det[DET_BUCK_OVERCUR] = buck_overcurrent_det;
    assign det[DET_BUCK_UNDERV] = buck_undervoltage_det;
    assign det[DET_PUMP_UNDERV] = charge_pump_undervoltage_det;

    // A detection in the clear cycle still sets its flag, so no event is lost.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DET; gi++)
        begin : g_flag
            assign flag_nxt[gi] = det[gi] | (flag_r[gi] & ~fault_clear);
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            flag_r <= FLAGS_RESET;
        else
            flag_r <= flag_nxt;
    end

    // Summaries are formed from the latched flags, so they clear together.
    assign overcur_any = |flag_r[DET_PHC_HIGH:DET_PHA_LOW];
    assign buck_any = flag_r[DET_BUCK_OVERCUR] | flag_r[DET_BUCK_UNDERV];
    assign therm_any = flag_r[DET_THERM_WARN] | flag_r[DET_THERM_SHUT];
    assign any_flag = |flag_r;

    always_comb
    begin
        gdf_image = GDF_RESET;
        gdf_image[BIT_SUMMARY] = any_flag;
        gdf_image[BIT_BUCK_ANY] = buck_any;
        gdf_image[BIT_OVERCUR_ANY] = overcur_any;
        gdf_image[BIT_SUPPLY_HIGH] = flag_r[DET_SUPPLY_HIGH];
        gdf_image[BIT_THERM_ANY] = therm_any;
        gdf_image[BIT_THERM_WARN] = flag_r[DET_THERM_WARN];
        gdf_image[BIT_THERM_SHUT] = flag_r[DET_THERM_SHUT];
        gdf_image[BIT_PHC_HIGH] = flag_r[DET_PHC_HIGH];
        gdf_image[BIT_PHC_LOW] = flag_r[DET_PHC_LOW];
        gdf_image[BIT_PHB_HIGH] = flag_r[DET_PHB_HIGH];
        gdf_image[BIT_PHB_LOW] = flag_r[DET_PHB_LOW];
        gdf_image[BIT_PHA_HIGH] = flag_r[DET_PHA_HIGH];
        gdf_image[BIT_PHA_LOW] = flag_r[DET_PHA_LOW];
        gdf_image[BIT_OTP_ERR] = flag_r[DET_OTP_ERR];
        gdf_image[BIT_BUCK_OVERCUR] = flag_r[DET_BUCK_OVERCUR];
        gdf_image[BIT_BUCK_UNDERV] = flag_r[DET_BUCK_UNDERV];
        gdf_image[BIT_PUMP_UNDERV] = flag_r[DET_PUMP_UNDERV];
    end

    // There is no write path at all, so software cannot disturb any offset.
    assign hit_gdf = (rd_addr == GDF_OFS);
    assign hit_cfs = (rd_addr == CFS_OFS);
    assign rd_data_nxt = !rd_en ? RD_IDLE :
                         hit_gdf ? gdf_image :
                         hit_cfs ? controller_fault_flags : RD_IDLE;
    assign rd_error_nxt = rd_en & ~hit_gdf & ~hit_cfs;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rd_data_r <= RD_IDLE;
            rd_valid_r <= 1'b0;
            rd_error_r <= 1'b0;
            driver_fault_r <= 1'b0;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_en;
            rd_error_r <= rd_error_nxt;
            driver_fault_r <= any_flag;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign rd_error = rd_error_r;
    assign driver_fault = driver_fault_r;

    property p_summary;
        @(posedge ref_clk) disable iff (reset)
        gdf_image[BIT_SUMMARY] == |(gdf_image & GDF_USED_MASK & ~(32'h80000000));
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary bit differs from OR of flags");

    property p_summary_out;
        @(posedge ref_clk) disable iff (reset)
        ##1 driver_fault == $past(any_flag);
    endproperty
    a_summary_out: assert property (p_summary_out)
        else $error("driver_fault does not follow flags");

    property p_buck;
        @(posedge ref_clk) disable iff (reset)
        (buck_overcurrent_det || buck_undervoltage_det) |=> gdf_image[BIT_BUCK_ANY];
    endproperty
    a_buck: assert property (p_buck)
        else $error("buck fault bit not set after detection");

    property p_ocp_any;
        @(posedge ref_clk) disable iff (reset)
        gdf_image[BIT_OVERCUR_ANY] == |gdf_image[BIT_PHC_HIGH:BIT_PHA_LOW];
    endproperty
    a_ocp_any: assert property (p_ocp_any)
        else $error("overcurrent summary differs from switch flags");

    property p_ovp;
        @(posedge ref_clk) disable iff (reset)
        supply_overvoltage_det |=> gdf_image[BIT_SUPPLY_HIGH];
    endproperty
    a_ovp: assert property (p_ovp)
        else $error("overvoltage bit not set after detection");

    property p_therm;
        @(posedge ref_clk) disable iff (reset)
        gdf_image[BIT_THERM_ANY] == (gdf_image[BIT_THERM_WARN] | gdf_image[BIT_THERM_SHUT]);
    endproperty
    a_therm: assert property (p_therm)
        else $error("thermal summary differs from warning or shutdown");

    property p_otw_ots;
        @(posedge ref_clk) disable iff (reset)
        (thermal_warning_det |=> gdf_image[BIT_THERM_WARN])
            and (thermal_shutdown_det |=> gdf_image[BIT_THERM_SHUT]);
    endproperty
    a_otw_ots: assert property (p_otw_ots)
        else $error("thermal bits not set after detection");

    property p_phase_c;
        @(posedge ref_clk) disable iff (reset)
        (phase_c_high_side_oc_det || phase_c_low_side_oc_det) |=>
            (gdf_image[BIT_PHC_HIGH] == $past(phase_c_high_side_oc_det) || $past(flag_r[DET_PHC_HIGH]))
            && (gdf_image[BIT_PHC_LOW] || !$past(phase_c_low_side_oc_det));
    endproperty
    a_phase_c: assert property (p_phase_c)
        else $error("phase C overcurrent bits wrong");

    property p_reserved;
        @(posedge ref_clk) disable iff (reset)
        (gdf_image & ~GDF_USED_MASK) == 32'h00000000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit reads as one");

    property p_read_gdf;
        @(posedge ref_clk) disable iff (reset)
        (rd_en && rd_addr == GDF_OFS) |=> rd_valid && !rd_error && rd_data == $past(gdf_image);
    endproperty
    a_read_gdf: assert property (p_read_gdf)
        else $error("read of fault register returned wrong data");

    property p_read_bad;
        @(posedge ref_clk) disable iff (reset)
        (rd_en && rd_addr != GDF_OFS && rd_addr != CFS_OFS) |=> rd_error && rd_data == RD_IDLE;
    endproperty
    a_read_bad: assert property (p_read_bad)
        else $error("reserved offset read not flagged");

    property p_phase_ab;
        @(posedge ref_clk) disable iff (reset)
        (phase_a_low_side_oc_det && phase_b_high_side_oc_det) |=>
            gdf_image[BIT_PHA_LOW] && gdf_image[BIT_PHB_HIGH] && gdf_image[BIT_OVERCUR_ANY];
    endproperty
    a_phase_ab: assert property (p_phase_ab)
        else $error("phase A or B overcurrent bit not set");

    property p_phase_ab_rest;
        @(posedge ref_clk) disable iff (reset)
        (phase_a_high_side_oc_det |=> gdf_image[BIT_PHA_HIGH])
            and (phase_b_low_side_oc_det |=> gdf_image[BIT_PHB_LOW]);
    endproperty
    a_phase_ab_rest: assert property (p_phase_ab_rest)
        else $error("phase A high or phase B low overcurrent bit not set");

    property p_buck_bits;
        @(posedge ref_clk) disable iff (reset)
        (buck_undervoltage_det |=> gdf_image[BIT_BUCK_UNDERV])
            and (buck_overcurrent_det |=> gdf_image[BIT_BUCK_OVERCUR]);
    endproperty
    a_buck_bits: assert property (p_buck_bits)
        else $error("buck undervoltage bit not set");

    property p_cp_otp;
        @(posedge ref_clk) disable iff (reset)
        (charge_pump_undervoltage_det |=> gdf_image[BIT_PUMP_UNDERV])
            and (otp_error_det |=> gdf_image[BIT_OTP_ERR]);
    endproperty
    a_cp_otp: assert property (p_cp_otp)
        else $error("charge pump or storage error bit not set");

    property p_hold;
        @(posedge ref_clk) disable iff (reset)
        (any_flag && !fault_clear) |=> any_flag [*1] ##0 ($past(flag_r) & ~flag_r) == FLAGS_RESET;
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag dropped without a clear");

    property p_clear;
        @(posedge ref_clk) disable iff (reset)
        (fault_clear && det == FLAGS_RESET) |=> flag_r == FLAGS_RESET ##1 !driver_fault;
    endproperty
    a_clear: assert property (p_clear)
        else $error("flags survive a clear with no detection");

    // A detection in the clear cycle must still leave its flag set afterwards.
    property p_det_sets;
        @(posedge ref_clk) disable iff (reset)
        (det != FLAGS_RESET) |=> (flag_r & $past(det)) == $past(det);
    endproperty
    a_det_sets: assert property (p_det_sets)
        else $error("detection did not set its flag");

    property p_read_cfs;
        @(posedge ref_clk) disable iff (reset)
        (rd_en && rd_addr == CFS_OFS) |=> rd_valid && !rd_error && rd_data == $past(controller_fault_flags);
    endproperty
    a_read_cfs: assert property (p_read_cfs)
        else $error("read of controller register returned wrong data");

    // Read outputs stand for one cycle only, so a stale word is never taken twice.
    property p_read_idle;
        @(posedge ref_clk) disable iff (reset)
        !rd_en |=> !rd_valid && !rd_error && rd_data == RD_IDLE;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read outputs stand without a request");

endmodule : gdf_fault_bank
`default_nettype wire

/* File: gdf_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module gdf_host_model
    import gdf_pkg::*;
(
    input wire logic ref_clk, // Device clock.
    input wire logic [DATA_W-1:0] rd_data, // Read data.
    input wire logic rd_valid, // Answer strobe.
    input wire logic rd_error, // Reserved offset hit.
    output logic rd_en, // Read request.
    output logic [ADDR_W-1:0] rd_addr // Register offset.
);
    // The host only ever reads, so reserved offsets are probed but never altered.
    initial
    begin
        rd_en = 1'b0;
        rd_addr = 8'h00;
    end

    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic e, output logic ok);
        int i;
        ok = 1'b0;
        d = 32'h00000000;
        e = 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        for (i = 0; i < 4 && !ok; i++)
        begin
            @(posedge ref_clk);
            rd_en <= 1'b0;
            // A released offset shows the inverse so a stale value is never trusted.
            rd_addr <= ~a;
            #1;
            if (rd_valid === 1'b1)
            begin
                ok = 1'b1;
                d = rd_data;
                e = rd_error;
            end
        end
    endtask : read
endmodule : gdf_host_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import gdf_pkg::*;
    logic ref_clk, reset, clr, rd_en, rd_valid, rd_error, drv_f;
    logic [NUM_DET-1:0] det;
    logic [7:0] rd_addr;
    logic [31:0] rd_data, cff;
    int n_mismatch, checked;
    localparam int POS [NUM_DET] = '{BIT_SUPPLY_HIGH, BIT_THERM_WARN, BIT_THERM_SHUT, BIT_PHA_LOW, BIT_PHA_HIGH,
        BIT_PHB_LOW, BIT_PHB_HIGH, BIT_PHC_LOW, BIT_PHC_HIGH, BIT_OTP_ERR, BIT_BUCK_OVERCUR, BIT_BUCK_UNDERV,
        BIT_PUMP_UNDERV};

    gdf_fault_bank u_dut (.ref_clk(ref_clk), .reset(reset), .supply_overvoltage_det(det[DET_SUPPLY_HIGH]),
        .thermal_warning_det(det[DET_THERM_WARN]), .thermal_shutdown_det(det[DET_THERM_SHUT]),
        .phase_a_low_side_oc_det(det[DET_PHA_LOW]), .phase_a_high_side_oc_det(det[DET_PHA_HIGH]),
        .phase_b_low_side_oc_det(det[DET_PHB_LOW]), .phase_b_high_side_oc_det(det[DET_PHB_HIGH]),
        .phase_c_low_side_oc_det(det[DET_PHC_LOW]), .phase_c_high_side_oc_det(det[DET_PHC_HIGH]),
        .otp_error_det(det[DET_OTP_ERR]), .buck_overcurrent_det(det[DET_BUCK_OVERCUR]),
        .buck_undervoltage_det(det[DET_BUCK_UNDERV]), .charge_pump_undervoltage_det(det[DET_PUMP_UNDERV]),
        .fault_clear(clr), .controller_fault_flags(cff), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_error(rd_error), .driver_fault(drv_f));
    gdf_host_model u_host (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_error(rd_error), .rd_en(rd_en), .rd_addr(rd_addr));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Summary bits are rebuilt here from the individual flags, independent of the design.
    function automatic logic [31:0] img(input logic [31:0] b);
        logic [31:0] r;
        r = b;
        r[30] = b[13] | b[12];
        r[28] = |b[21:16];
        r[25] = b[23] | b[22];
        r[31] = |r[30:0];
        return r;
    endfunction : img

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic e);
        logic ok;
        u_host.read(a, d, e, ok);
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("mismatch at %0t: read got no answer", $time);
            conclude();
        end
    endtask : rd

    task automatic pulse(input logic [NUM_DET-1:0] d, input logic c);
        @(posedge ref_clk);
        det <= d;
        clr <= c;
        @(posedge ref_clk);
        det <= FLAGS_RESET;
        clr <= 1'b0;
    endtask : pulse

    task automatic t_each_flag();
        int k;
        logic [31:0] d, b;
        logic e;
        for (k = 0; k < NUM_DET; k++)
        begin
            b = 32'h00000000;
            b[POS[k]] = 1'b1;
            pulse(13'h0001 << k, 1'b0);
            rd(GDF_OFS, d, e);
            chk(d, img(b));
            chk({31'h00000000, e}, 32'h00000000);
            chk({31'h00000000, drv_f}, 32'h00000001);
            pulse(FLAGS_RESET, 1'b1);
            rd(GDF_OFS, d, e);
            chk(d, GDF_RESET);
            chk({31'h00000000, drv_f}, 32'h00000000);
        end
    endtask : t_each_flag

    // A clear landing with a detection must not lose that detection.
    task automatic t_set_wins();
        logic [31:0] d, b;
        logic e;
        b = 32'h00000000;
        b[BIT_THERM_SHUT] = 1'b1;
        pulse(13'h0001 << DET_THERM_SHUT, 1'b1);
        rd(GDF_OFS, d, e);
        chk(d, img(b));
        pulse(FLAGS_RESET, 1'b1);
    endtask : t_set_wins

    task automatic t_reserved_and_reset();
        int i;
        logic [31:0] d;
        logic e;
        pulse(~FLAGS_RESET, 1'b0);
        rd(GDF_OFS, d, e);
        chk(d, img(GDF_USED_MASK & 32'h04FF7800));
        rd(CFS_OFS, d, e);
        chk(d, cff);
        chk({31'h00000000, e}, 32'h00000000);
        for (i = 0; i < 8; i++)
        begin
            if (8'hDC + i != GDF_OFS && 8'hDC + i != CFS_OFS)
            begin
                rd(8'hDC + i[7:0], d, e);
                chk(d, RD_IDLE);
                chk({31'h00000000, e}, 32'h00000001);
            end
        end
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(GDF_OFS, d, e);
        chk(d, GDF_RESET);
        chk({31'h00000000, drv_f}, 32'h00000000);
    endtask : t_reserved_and_reset

    initial
    begin
        n_mismatch = 0;
        checked = 0;
        reset = 1'b1;
        clr = 1'b0;
        det = FLAGS_RESET;
        cff = 32'hA5C30F01;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        t_each_flag();
        t_set_wins();
        t_reserved_and_reset();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
